// ---- core/rsfec_rx_pkg.sv ----
// constants and types shared by the receive fec control and status block
package rsfec_rx_pkg;

	// =====================================================
	// register port geometry
	localparam int          ADDR_W = 16;
	localparam int          DATA_W = 32;
	localparam int          IDX_W  = 14;

	// =====================================================
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_REVISION   = 14'h0d00;
	localparam logic [IDX_W-1:0] IDX_STRING0    = 14'h0d01;
	localparam logic [IDX_W-1:0] IDX_STRING1    = 14'h0d02;
	localparam logic [IDX_W-1:0] IDX_STRING2    = 14'h0d03;
	localparam logic [IDX_W-1:0] IDX_CONTROL    = 14'h0d04;
	localparam logic [IDX_W-1:0] IDX_LOCK       = 14'h0d05;
	localparam logic [IDX_W-1:0] IDX_FIXED_CNT  = 14'h0d06;
	localparam logic [IDX_W-1:0] IDX_UNFIX_CNT  = 14'h0d07;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 14'h0d08;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 14'h0d09;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 14'h0d0a;

	// =====================================================
	// field positions
	localparam int CTRL_BYPASS_BIT = 0;
	localparam int CTRL_RESYNC_BIT = 4;
	localparam int LOCK_BIT        = 0;

	// interrupt event bits
	localparam int EV_LOCK_GAINED = 0;
	localparam int EV_LOCK_LOST   = 1;
	localparam int EV_FIXED_CW    = 2;
	localparam int EV_UNFIX_CW    = 3;
	localparam int EV_COUNT       = 4;

	// =====================================================
	// reset values
	localparam logic [DATA_W-1:0]   CTRL_RESET    = 32'h0000_0000;
	localparam logic [DATA_W-1:0]   COUNT_RESET   = 32'h0000_0000;
	localparam logic [EV_COUNT-1:0] IRQ_RESET     = 4'h0;

	// identification words, values arbitrary
	localparam logic [DATA_W-1:0] REVISION_WORD = 32'h0001_0000;
	localparam logic [DATA_W-1:0] STRING_WORD0  = 32'h7278_6665;
	localparam logic [DATA_W-1:0] STRING_WORD1  = 32'h6364_6563;
	localparam logic [DATA_W-1:0] STRING_WORD2  = 32'h6f64_6531;

	// =====================================================
	// timing
	localparam int CLK_PERIOD_NS    = 8;
	localparam int RX_RESET_HOLD_NS = 64;
	localparam int RX_RESET_HOLD_CYCLES = (RX_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = 4;

	// link supervision states
	typedef enum logic [1:0] {
		ST_WAIT_LOCK,
		ST_LOCKED,
		ST_RX_RESET
	} link_state_t;

endpackage

// ---- core/cw_sat_counter.sv ----
// saturating codeword counter that clears when read
`timescale 1ns/10ps
module cw_sat_counter
	import rsfec_rx_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic              countEvent,
	input  wire logic              readClear,
	output logic [DATA_W-1:0]      count
);

	// =====================================================
	// counter
	logic [DATA_W-1:0] count_r;

	// an event in the clearing cycle is kept, so none is lost
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			count_r <= COUNT_RESET;
		else if (readClear)
			count_r <= {{(DATA_W-1){1'b0}}, countEvent};
		else if (countEvent && !(&count_r))
			count_r <= count_r + 32'h0000_0001;
	end

	assign count = count_r;

endmodule

// ---- core/rsfec_rx_control_status.sv ----
// control, status and codeword counters of the receive fec decoder
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps

module rsfec_rx_control_status
	import rsfec_rx_pkg::*;
(
	input  wire logic                         clk_sys,
	input  wire logic                         resetn,
	input  wire logic [rsfec_rx_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [rsfec_rx_pkg::DATA_W-1:0] regWrData,
	input  wire logic                         regWrEn,
	input  wire logic                         regRdEn,
	output logic      [rsfec_rx_pkg::DATA_W-1:0] regRdData,
	input  wire logic                         amLockIn,
	input  wire logic                         resyncAck,
	input  wire logic                         fixedCwStrobe,
	input  wire logic                         unfixableCwStrobe,
	output logic                              bypassCorrection,
	output logic                              resyncRequest,
	output logic                              pcsReady,
	output logic                              softRxReset,
	output logic                              irq
);

	// =====================================================
	// address decode
	function automatic logic hitIdx(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
		hitIdx = (addr[ADDR_W-1:2] == idx);
	endfunction

	logic ctrlWr;
	logic irqEnWr;
	logic irqClrWr;
	logic fixedRd;
	logic unfixRd;

	// writes to read-only words fall through without effect
	assign ctrlWr   = regWrEn && hitIdx(regAddr, IDX_CONTROL);
	assign irqEnWr  = regWrEn && hitIdx(regAddr, IDX_IRQ_ENABLE);
	assign irqClrWr = regWrEn && hitIdx(regAddr, IDX_IRQ_CLEAR);
	assign fixedRd  = regRdEn && hitIdx(regAddr, IDX_FIXED_CNT);
	assign unfixRd  = regRdEn && hitIdx(regAddr, IDX_UNFIX_CNT);

	// =====================================================
	// control word
	logic bypass_r;
	logic resync_r;

	// only bits 0 and 4 are stored, the rest is dropped
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			bypass_r <= CTRL_RESET[CTRL_BYPASS_BIT];
		else if (ctrlWr)
			bypass_r <= regWrData[CTRL_BYPASS_BIT];
	end

	// a fresh write beats the aligner's acknowledge of the old request
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			resync_r <= CTRL_RESET[CTRL_RESYNC_BIT];
		else if (ctrlWr)
			resync_r <= regWrData[CTRL_RESYNC_BIT];
		else if (resyncAck)
			resync_r <= 1'b0;
	end

	assign bypassCorrection = bypass_r;
	assign resyncRequest    = resync_r;

	// =====================================================
	// lock status and link supervision
	logic                lock_r;
	link_state_t         state_r;
	logic [HOLD_W-1:0]   holdCnt_r;
	logic                pcsReady_r;
	logic                softRxReset_r;

	// marker lock taken as a plain registered level
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			lock_r <= 1'b0;
		else
			lock_r <= amLockIn;
	end

	// ready only while locked; a lost lock forces a timed receive reset
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_r       <= ST_WAIT_LOCK;
			holdCnt_r     <= '0;
			pcsReady_r    <= 1'b0;
			softRxReset_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_WAIT_LOCK:
				begin
					if (lock_r)
					begin
						state_r    <= ST_LOCKED;
						pcsReady_r <= 1'b1;
					end
				end
				ST_LOCKED:
				begin
					if (!lock_r)
					begin
						state_r       <= ST_RX_RESET;
						pcsReady_r    <= 1'b0;
						softRxReset_r <= 1'b1;
						holdCnt_r     <= HOLD_W'(RX_RESET_HOLD_CYCLES - 1);
					end
				end
				ST_RX_RESET:
				begin
					if (holdCnt_r == '0)
					begin
						state_r       <= ST_WAIT_LOCK;
						softRxReset_r <= 1'b0;
					end
					else
						holdCnt_r <= holdCnt_r - HOLD_W'(1);
				end
				default:
				begin
					state_r       <= ST_WAIT_LOCK;
					pcsReady_r    <= 1'b0;
					softRxReset_r <= 1'b0;
				end
			endcase
		end
	end

	assign pcsReady    = pcsReady_r;
	assign softRxReset = softRxReset_r;

	// =====================================================
	// codeword counters
	logic [DATA_W-1:0] fixedCount;
	logic [DATA_W-1:0] unfixCount;

	// corrected codewords
	cw_sat_counter fixedCounter (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.countEvent (fixedCwStrobe),
		.readClear  (fixedRd),
		.count      (fixedCount)
	);

	// uncorrectable codewords
	cw_sat_counter unfixCounter (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.countEvent (unfixableCwStrobe),
		.readClear  (unfixRd),
		.count      (unfixCount)
	);

	// =====================================================
	// interrupt status, enable and clear
	logic [EV_COUNT-1:0] events;
	logic [EV_COUNT-1:0] irqStatus_r;
	logic [EV_COUNT-1:0] irqEnable_r;
	logic                irq_r;

	// lock edges seen one cycle early from the raw input
	assign events[EV_LOCK_GAINED] = amLockIn && !lock_r;
	assign events[EV_LOCK_LOST]   = !amLockIn && lock_r;
	assign events[EV_FIXED_CW]    = fixedCwStrobe;
	assign events[EV_UNFIX_CW]    = unfixableCwStrobe;

	// sticky bits; an event in the clearing cycle wins
	for (genvar i = 0; i < EV_COUNT; i++)
	begin : g_status
		always_ff @(posedge clk_sys)
		begin
			if (!resetn)
				irqStatus_r[i] <= IRQ_RESET[i];
			else if (events[i])
				irqStatus_r[i] <= 1'b1;
			else if (irqClrWr && regWrData[i])
				irqStatus_r[i] <= 1'b0;
		end
	end

	// enable mask
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			irqEnable_r <= IRQ_RESET;
		else if (irqEnWr)
			irqEnable_r <= regWrData[EV_COUNT-1:0];
	end

	// registered level, trails the status by one cycle
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			irq_r <= 1'b0;
		else
			irq_r <= |(irqStatus_r & irqEnable_r);
	end

	assign irq = irq_r;

	// =====================================================
	// read path
	logic [DATA_W-1:0] rdMux;
	logic [DATA_W-1:0] rdData_r;

	// unmapped and write-only words read zero
	always_comb
	begin
		rdMux = '0;
		case (regAddr[ADDR_W-1:2])
			IDX_REVISION:   rdMux = REVISION_WORD;
			IDX_STRING0:    rdMux = STRING_WORD0;
			IDX_STRING1:    rdMux = STRING_WORD1;
			IDX_STRING2:    rdMux = STRING_WORD2;
			IDX_CONTROL:
			begin
				rdMux[CTRL_BYPASS_BIT] = bypass_r;
				rdMux[CTRL_RESYNC_BIT] = resync_r;
			end
			IDX_LOCK:       rdMux[LOCK_BIT] = lock_r;
			IDX_FIXED_CNT:  rdMux = fixedCount;
			IDX_UNFIX_CNT:  rdMux = unfixCount;
			IDX_IRQ_STATUS: rdMux[EV_COUNT-1:0] = irqStatus_r;
			IDX_IRQ_ENABLE: rdMux[EV_COUNT-1:0] = irqEnable_r;
			default:        rdMux = '0;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			rdData_r <= '0;
		else if (regRdEn)
			rdData_r <= rdMux;
		else
			rdData_r <= '0;
	end

	assign regRdData = rdData_r;

	// =====================================================
	// checks
	a_bypass_follows_write: assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrlWr |=> bypassCorrection == $past(regWrData[CTRL_BYPASS_BIT]))
		else $error("bypass bit does not follow control write");

	a_resync_self_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		resyncRequest && resyncAck && !ctrlWr |=> !resyncRequest)
		else $error("resync request not cleared after acknowledge");

	a_resync_write_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrlWr |=> resyncRequest == $past(regWrData[CTRL_RESYNC_BIT]))
		else $error("resync bit does not follow control write");

	a_lock_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
		regRdEn && hitIdx(regAddr, IDX_LOCK) |=> regRdData == {31'h0000_0000, $past(lock_r)})
		else $error("lock status read wrong");

	a_fixed_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
		fixedCwStrobe && !fixedRd && !(&fixedCount) |=> fixedCount == $past(fixedCount) + 32'h0000_0001)
		else $error("corrected codeword not counted");

	a_unfix_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
		unfixableCwStrobe && !unfixRd && !(&unfixCount) |=> unfixCount == $past(unfixCount) + 32'h0000_0001)
		else $error("uncorrected codeword not counted");

	a_count_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		(fixedRd && !fixedCwStrobe) or (&fixedCount && !fixedRd) |=> fixedCount == (&$past(fixedCount) && !$past(fixedRd) ? 32'hffff_ffff : 32'h0000_0000))
		else $error("counter neither cleared on read nor held at maximum");

	a_ident_word_read: assert property (@(posedge clk_sys) disable iff (!resetn)
		regRdEn && hitIdx(regAddr, IDX_STRING1) |=> regRdData == STRING_WORD1)
		else $error("identification word read wrong");

	a_ready_drop_loss: assert property (@(posedge clk_sys) disable iff (!resetn)
		pcsReady && !lock_r |=> !pcsReady && softRxReset)
		else $error("pcs ready kept after lock loss");

	a_rx_reset_length: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(softRxReset) |-> softRxReset[*8] ##1 !softRxReset)
		else $error("soft receive reset length wrong");

	a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		regRdEn && (hitIdx(regAddr, IDX_CONTROL) || hitIdx(regAddr, IDX_LOCK))
		|=> regRdData[31:5] == 27'h000_0000 && regRdData[3:1] == 3'h0)
		else $error("reserved bits read nonzero");

	// =====================================================
	// checks on holding behaviour, read clear pairing and the read port
	a_bypass_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		!ctrlWr |=> $stable(bypassCorrection))
		else $error("bypass bit changed without a control write");

	a_resync_held: assert property (@(posedge clk_sys) disable iff (!resetn)
		resyncRequest && !resyncAck && !ctrlWr |=> resyncRequest)
		else $error("resync request dropped before acknowledge");

	a_ready_needs_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
		!pcsReady && !lock_r |=> !pcsReady)
		else $error("pcs ready raised without marker lock");

	a_reset_not_ready: assert property (@(posedge clk_sys) disable iff (!resetn)
		softRxReset |-> !pcsReady)
		else $error("pcs ready high during soft receive reset");

	a_unfix_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		unfixRd && !unfixableCwStrobe |=> unfixCount == 32'h0000_0000)
		else $error("uncorrected counter not cleared on read");

	a_clear_keeps_event: assert property (@(posedge clk_sys) disable iff (!resetn)
		fixedRd && fixedCwStrobe |=> fixedCount == 32'h0000_0001)
		else $error("codeword lost in the clearing cycle");

	a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
		(|(irqStatus_r & irqEnable_r)) |=> irq)
		else $error("interrupt not raised for enabled status");

	a_read_idle_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		!regRdEn |=> regRdData == 32'h0000_0000)
		else $error("read data not zero outside the answer cycle");

endmodule

// ---- test/rx_lane_model.sv ----
// behavioural model of the aligner and decoder that feed the control block
`timescale 1ns/10ps
module rx_lane_model
(
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       lockWanted,
	input  wire logic       fixReq,
	input  wire logic       unfixReq,
	input  wire logic [3:0] ackDelay,
	input  wire logic       resyncRequest,
	output logic            amLockIn,
	output logic            resyncAck,
	output logic            fixedCwStrobe,
	output logic            unfixableCwStrobe
);
	logic [3:0] waitCnt_r;

	// =====================================================
	// lock level and codeword outcomes, one cycle behind the bench
	always_ff @(posedge clk_sys)
	begin
		amLockIn          <= resetn & lockWanted;
		fixedCwStrobe     <= resetn & fixReq;
		unfixableCwStrobe <= resetn & unfixReq;
	end

	// restart answer after a chosen delay; a slow answer shows the request is held
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || !resyncRequest)
		begin
			waitCnt_r <= 4'h0;
			resyncAck <= 1'b0;
		end
		else if (waitCnt_r == ackDelay)
		begin
			waitCnt_r <= 4'h0;
			resyncAck <= 1'b1;
		end
		else
		begin
			waitCnt_r <= waitCnt_r + 4'h1;
			resyncAck <= 1'b0;
		end
	end
endmodule

// ---- test/rsfec_rx_control_status_tb.sv ----
// self-checking bench for the receive fec control and status block
`timescale 1ns/10ps
module rsfec_rx_control_status_tb;
	import rsfec_rx_pkg::*;

	logic              clk_sys, resetn, regWrEn, regRdEn;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData, rd, rnd;
	logic              amLockIn, resyncAck, fixedCwStrobe, unfixableCwStrobe;
	logic              bypassCorrection, resyncRequest, pcsReady, softRxReset, irq;
	logic              lockWanted, fixReq, unfixReq;
	logic [3:0]        ackDelay;
	int                err_total, checks, seed, cycles, n, k;

	rsfec_rx_control_status u_dut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.amLockIn(amLockIn), .resyncAck(resyncAck), .fixedCwStrobe(fixedCwStrobe),
		.unfixableCwStrobe(unfixableCwStrobe), .bypassCorrection(bypassCorrection),
		.resyncRequest(resyncRequest), .pcsReady(pcsReady), .softRxReset(softRxReset), .irq(irq));

	rx_lane_model u_lanes (.clk_sys(clk_sys), .resetn(resetn), .lockWanted(lockWanted), .fixReq(fixReq),
		.unfixReq(unfixReq), .ackDelay(ackDelay), .resyncRequest(resyncRequest), .amLockIn(amLockIn),
		.resyncAck(resyncAck), .fixedCwStrobe(fixedCwStrobe), .unfixableCwStrobe(unfixableCwStrobe));

	// =====================================================
	// clock, hang guard and closing report
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			$display("[FAIL] %0t run did not finish in time", $time);
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// =====================================================
	// compares and expectations
	task automatic chkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// only the bypass and restart bits survive a write
	function automatic logic [DATA_W-1:0] ctrlExpect(input logic [DATA_W-1:0] w);
		return w & 32'h0000_0011;
	endfunction

	// =====================================================
	// register port, strobes released right after the taking edge
	task automatic tick(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask

	task automatic regWrite(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data);
		@(posedge clk_sys);
		regAddr   <= {idx, 2'b00};
		regWrData <= data;
		regWrEn   <= 1'b1;
		@(posedge clk_sys);
		regWrEn   <= 1'b0;
		#1;
	endtask

	task automatic regRead(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] data);
		@(posedge clk_sys);
		regAddr <= {idx, 2'b00};
		regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1;
		data = regRdData;
	endtask

	task automatic pulseFix();
		@(posedge clk_sys);
		fixReq <= 1'b1;
		@(posedge clk_sys);
		fixReq <= 1'b0;
		tick(4);
	endtask

	// =====================================================
	// main sequence
	initial
	begin
		seed = 80;
		err_total = 0;
		checks = 0;
		cycles = 0;
		resetn = 1'b0;
		regAddr = '0;
		regWrData = '0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		lockWanted = 1'b0;
		fixReq = 1'b0;
		unfixReq = 1'b0;
		ackDelay = 4'h2;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		// identification, reset values, a read-only write and an unmapped read
		regRead(IDX_REVISION, rd); chkWord(rd, REVISION_WORD);
		regRead(IDX_STRING0, rd); chkWord(rd, STRING_WORD0);
		regRead(IDX_STRING1, rd); chkWord(rd, STRING_WORD1);
		regRead(IDX_STRING2, rd); chkWord(rd, STRING_WORD2);
		regRead(IDX_CONTROL, rd); chkWord(rd, CTRL_RESET);
		regRead(IDX_LOCK, rd); chkWord(rd, 32'h0000_0000);
		regRead(IDX_FIXED_CNT, rd); chkWord(rd, COUNT_RESET);
		regRead(IDX_UNFIX_CNT, rd); chkWord(rd, COUNT_RESET);
		regRead(14'h0d0f, rd); chkWord(rd, 32'h0000_0000);
		regWrite(IDX_STRING0, 32'h0000_0000);
		regRead(IDX_STRING0, rd); chkWord(rd, STRING_WORD0);
		// control on with every reserved bit set, then off with all bits clear
		regWrite(IDX_CONTROL, 32'hffff_ffef); chkBit(bypassCorrection, 1'b1);
		chkBit(resyncRequest, 1'b0);
		regRead(IDX_CONTROL, rd); chkWord(rd, ctrlExpect(32'hffff_ffef));
		regWrite(IDX_CONTROL, 32'h0000_0000); chkBit(bypassCorrection, 1'b0);
		// restart answered fast, then slow; bypass must survive the self-clear
		for (k = 0; k < 2; k++)
		begin
			ackDelay <= k ? 4'h9 : 4'h2;
			regWrite(IDX_CONTROL, 32'h0000_0011); chkBit(resyncRequest, 1'b1);
			n = 0;
			while (resyncRequest === 1'b1 && n < 30)
			begin
				tick(1);
				n++;
			end
			regRead(IDX_CONTROL, rd); chkWord(rd, 32'h0000_0001);
		end
		// lock, then loss of signal
		lockWanted <= 1'b1;
		tick(4);
		regRead(IDX_LOCK, rd); chkWord(rd, 32'h0000_0001);
		chkBit(pcsReady, 1'b1);
		lockWanted <= 1'b0;
		n = 0;
		while (softRxReset !== 1'b1 && n < 10)
		begin
			tick(1);
			n++;
		end
		chkBit(pcsReady, 1'b0);
		n = 0;
		while (softRxReset === 1'b1 && n < 20)
		begin
			tick(1);
			n++;
		end
		chkWord(n, RX_RESET_HOLD_CYCLES);
		regRead(IDX_LOCK, rd); chkWord(rd, 32'h0000_0000);
		// random codeword bursts on each counter, then read twice
		for (k = 0; k < 2; k++)
		begin
			n = 0;
			repeat (40)
			begin
				@(posedge clk_sys);
				rnd = $random(seed);
				fixReq <= (k == 0) & rnd[0];
				unfixReq <= (k == 1) & rnd[0];
				n += rnd[0];
			end
			@(posedge clk_sys);
			fixReq <= 1'b0;
			unfixReq <= 1'b0;
			tick(3);
			regRead(k ? IDX_UNFIX_CNT : IDX_FIXED_CNT, rd); chkWord(rd, n);
			regRead(k ? IDX_UNFIX_CNT : IDX_FIXED_CNT, rd); chkWord(rd, 32'h0000_0000);
		end
		// interrupt raised, cleared, then masked
		regWrite(IDX_IRQ_CLEAR, 32'h0000_000f);
		regWrite(IDX_IRQ_ENABLE, 32'h0000_0004);
		tick(2);
		chkBit(irq, 1'b0);
		pulseFix();
		chkBit(irq, 1'b1);
		regRead(IDX_IRQ_STATUS, rd);
		chkWord(rd & 32'h0000_0004, 32'h0000_0004);
		regWrite(IDX_IRQ_CLEAR, 32'h0000_0004);
		tick(2);
		chkBit(irq, 1'b0);
		regWrite(IDX_IRQ_ENABLE, 32'h0000_0000);
		pulseFix();
		chkBit(irq, 1'b0);
		regRead(IDX_IRQ_STATUS, rd);
		chkWord(rd & 32'h0000_0004, 32'h0000_0004);
		// corner: a codeword lands in the clearing read, the two earlier pulses read back
		@(posedge clk_sys);
		fixReq <= 1'b1;
		@(posedge clk_sys);
		fixReq  <= 1'b0;
		regAddr <= {IDX_FIXED_CNT, 2'b00};
		regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1;
		chkWord(regRdData, 32'h0000_0002);
		regRead(IDX_FIXED_CNT, rd); chkWord(rd, 32'h0000_0001);
		conclude();
	end
endmodule
